// File: logic/ipq_top.sv
// Purpose: decides whether an access on the access page raises a guest exit
// Assumes: the pipeline holds its flag inputs until answered; check inputs count only with chk_valid
// Notes: one access in flight; exit_req, fault_fwd and mem_go are one-cycle pulses
`timescale 1ns/10ps
module ipq_top #(
	parameter int AW           = 52,
	parameter bit ZMASK_FAULTS = 1'b1,
	parameter bit SKIP_LARGE   = 1'b1,
	parameter bit SKIP_STALE   = 1'b1
) (
	// clock and reset
	input  wire logic                         mclk,
	input  wire logic                         resetn,
	// controls
	input  wire logic                         virt_access_ctl,
	input  wire logic [31:0]                  prim_exec_ctl,
	input  wire logic                         slt_enable_ctl,
	input  wire logic [AW-ipq_pkg::PAGE_SHIFT-1:0] access_page_base,
	// processor mode
	input  wire logic                         paging_enable_flag,
	input  wire logic                         phys_addr_extension_flag,
	input  wire logic                         long_mode_active_flag,
	// access request
	input  wire logic                         req_valid,
	output logic                              req_ready,
	input  wire logic [AW-1:0]                req_phys_addr,
	input  wire logic                         req_lin_gen,
	input  wire logic                         req_lin_xlat,
	input  wire logic                         req_from_slt,
	input  wire ipq_pkg::ipq_acc_t            req_kind,
	input  wire ipq_pkg::ipq_instr_t          req_instr,
	input  wire logic                         req_write,
	input  wire logic                         req_zero_mask,
	input  wire logic                         req_rep,
	input  wire logic [ipq_pkg::ITER_W-1:0]   req_iter,
	// translation used
	input  wire logic                         third_level_pointer_entry_used,
	input  wire logic [ipq_pkg::ENTRY_W-1:0]  third_level_pointer_entry_entry,
	input  wire logic                         pde_used,
	input  wire logic [ipq_pkg::ENTRY_W-1:0]  pde_entry,
	input  wire logic                         stale_xlat,
	// fault checks and flag updates
	input  wire logic                         chk_valid,
	input  wire logic                         chk_page_fault,
	input  wire logic                         chk_slt_viol,
	input  wire logic                         acc_flags_set,
	input  wire logic                         dirty_flag_set,
	// results
	output logic                              exit_req,
	output ipq_pkg::ipq_class_t               exit_class,
	output logic [ipq_pkg::ITER_W-1:0]        exit_iter,
	output logic                              exit_hold_ip,
	output logic                              fault_fwd,
	output logic                              mem_go,
	output logic                              pae_active
);
	import ipq_pkg::*;

	function automatic logic page_hit(input logic [AW-1:0] a,
		input logic [AW-PAGE_SHIFT-1:0] b);
		page_hit = a[AW-1:PAGE_SHIFT] == b;
	endfunction

	ipq_cls_if  cls ();

	ipq_state_t              st_reg;
	ipq_state_t              st_next;
	logic [AW-1:0]           cap_addr;
	logic                    cap_lin_gen;
	logic                    cap_lin_xlat;
	logic                    cap_from_slt;
	ipq_acc_t                cap_kind;
	ipq_instr_t              cap_instr;
	logic                    cap_wr;
	logic                    cap_zm;
	logic                    cap_rep;
	logic [ITER_W-1:0]       cap_iter;
	logic                    cap_third_level_pointer_entry_used;
	logic [ENTRY_W-1:0]      cap_third_level_pointer_entry;
	logic                    cap_pde_used;
	logic [ENTRY_W-1:0]      cap_pde;
	logic                    cap_stale;
	logic                    suppress;
	logic                    force_read;

	wire take     = req_valid & req_ready;
	wire prim_on  = prim_exec_ctl[PRIM_SEC_BIT];
	wire slt_eff  = slt_enable_ctl & prim_on;
	wire virt_eff = virt_access_ctl & prim_on;
	// physical address only; the guest address never reaches here
	wire on_page  = page_hit(cap_addr, access_page_base);
	wire faulted  = chk_page_fault | chk_slt_viol;
	wire cand     = virt_eff & on_page & (cls.is_lin | cls.is_gp)
		& !suppress;
	wire wr_eff   = cap_wr & !force_read;
	wire ad_done  = acc_flags_set & (dirty_flag_set | !wr_eff);
	wire chk_now  = (st_reg == IPQ_S_CHECK) & chk_valid;
	wire fault_ev = chk_now & faulted;
	wire lin_go   = chk_now & !faulted & cand & cls.is_lin;
	wire gp_exit  = chk_now & !faulted & cand & cls.is_gp;
	wire miss_ev  = chk_now & !faulted & !cand;
	wire ad_exit  = (st_reg == IPQ_S_ADWAIT) & ad_done;
	wire exit_ev  = gp_exit | ad_exit;
	wire done_ev  = exit_ev | fault_ev | miss_ev;

	assign cls.paging_enable_flag       = paging_enable_flag;
	assign cls.phys_addr_extension_flag = phys_addr_extension_flag;
	assign cls.long_mode_active_flag    = long_mode_active_flag;
	assign cls.slt_eff                  = slt_eff;
	assign cls.from_slt                 = cap_from_slt;
	assign cls.lin_gen                  = cap_lin_gen;
	assign cls.lin_xlat                 = cap_lin_xlat;
	assign cls.kind                     = cap_kind;

	ipq_classify u_cls (
		.c (cls.cls)
	);

	ipq_filter #(
		.ZMASK_FAULTS (ZMASK_FAULTS),
		.SKIP_LARGE   (SKIP_LARGE),
		.SKIP_STALE   (SKIP_STALE)
	) u_flt (
		.instr       (cap_instr),
		.zero_mask   (cap_zm),
		.is_gp       (cls.is_gp),
		.third_level_pointer_entry_used  (cap_third_level_pointer_entry_used),
		.third_level_pointer_entry_entry (cap_third_level_pointer_entry),
		.pde_used    (cap_pde_used),
		.pde_entry   (cap_pde),
		.stale_xlat  (cap_stale),
		.suppress    (suppress),
		.force_read  (force_read)
	);

	always_comb begin
		st_next = st_reg;
		case (st_reg)
		IPQ_S_IDLE: begin
			if (take)
				st_next = IPQ_S_CHECK;
		end
		IPQ_S_CHECK: begin
			if (lin_go)
				st_next = IPQ_S_ADWAIT;
			else if (chk_valid)
				st_next = IPQ_S_IDLE;
		end
		IPQ_S_ADWAIT: begin
			if (ad_done)
				st_next = IPQ_S_IDLE;
		end
		default: st_next = IPQ_S_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			st_reg <= IPQ_S_IDLE;
		else
			st_reg <= st_next;
	end

	// request fields held for the whole decision
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cap_addr       <= '0;
			cap_lin_gen    <= RST_BIT;
			cap_lin_xlat   <= RST_BIT;
			cap_from_slt   <= RST_BIT;
			cap_kind       <= IPQ_A_DATA;
			cap_instr      <= IPQ_I_NORMAL;
			cap_wr         <= RST_BIT;
			cap_zm         <= RST_BIT;
			cap_rep        <= RST_BIT;
			cap_iter       <= RST_ITER;
			cap_third_level_pointer_entry_used <= RST_BIT;
			cap_third_level_pointer_entry      <= '0;
			cap_pde_used   <= RST_BIT;
			cap_pde        <= '0;
			cap_stale      <= RST_BIT;
		end else if (take) begin
			cap_addr       <= req_phys_addr;
			cap_lin_gen    <= req_lin_gen;
			cap_lin_xlat   <= req_lin_xlat;
			cap_from_slt   <= req_from_slt;
			cap_kind       <= req_kind;
			cap_instr      <= req_instr;
			cap_wr         <= req_write;
			cap_zm         <= req_zero_mask;
			cap_rep        <= req_rep;
			cap_iter       <= req_iter;
			cap_third_level_pointer_entry_used <= third_level_pointer_entry_used;
			cap_third_level_pointer_entry      <= third_level_pointer_entry_entry;
			cap_pde_used   <= pde_used;
			cap_pde        <= pde_entry;
			cap_stale      <= stale_xlat;
		end
	end

	// exit shares the fault result slot
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			req_ready    <= RST_READY;
			exit_req     <= RST_BIT;
			exit_class   <= IPQ_CLS_LIN;
			exit_iter    <= RST_ITER;
			exit_hold_ip <= RST_BIT;
			fault_fwd    <= RST_BIT;
			mem_go       <= RST_BIT;
			pae_active   <= RST_BIT;
		end else begin
			req_ready  <= (req_ready & !take) | done_ev;
			exit_req   <= exit_ev;
			fault_fwd  <= fault_ev;
			mem_go     <= miss_ev;
			pae_active <= cls.pae_act;
			if (exit_ev) begin
				exit_class   <= gp_exit ? IPQ_CLS_GP : IPQ_CLS_LIN;
				exit_iter    <= cap_iter;
				exit_hold_ip <= cap_rep;
			end
		end
	end

	default clocking dc @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_lin_fault;
		chk_now && chk_page_fault;
	endsequence
	sequence s_lin_cand;
		lin_go && !acc_flags_set;
	endsequence
	sequence s_no_exit2;
		!exit_req ##1 !exit_req;
	endsequence

	AST_FAULT_CANCELS: assert property (
		s_lin_fault |=> fault_fwd ##0 s_no_exit2)
		else $error("exit raised despite page fault");
	AST_VIOL_CANCELS: assert property (
		chk_now && chk_slt_viol |=> fault_fwd && !exit_req)
		else $error("exit raised despite translation violation");
	AST_ACC_FIRST: assert property (
		exit_req && exit_class == IPQ_CLS_LIN |-> $past(acc_flags_set))
		else $error("linear exit before accessed flags set");
	AST_DIRTY_FIRST: assert property (
		exit_req && exit_class == IPQ_CLS_LIN && wr_eff
		|-> $past(dirty_flag_set))
		else $error("linear write exit before dirty flag set");
	AST_LIN_WAITS: assert property (
		s_lin_cand |=> !exit_req && st_reg == IPQ_S_ADWAIT)
		else $error("linear exit did not wait for flags");
	AST_ONE_SLOT: assert property (
		$onehot0({exit_req, fault_fwd, mem_go}))
		else $error("more than one result in a slot");
	AST_EXIT_ON_PAGE: assert property (
		exit_req |-> $past(on_page && virt_eff))
		else $error("exit for an address off the access page");
	AST_GP_EXIT: assert property (
		gp_exit |=> exit_req && exit_class == IPQ_CLS_GP)
		else $error("guest-physical exit missing or mistagged");
	AST_ITER_KEPT: assert property (
		exit_req |-> exit_hold_ip == cap_rep && exit_iter == cap_iter)
		else $error("string exit lost iteration count");
	AST_HINT_NONE: assert property (
		chk_now && cap_instr == IPQ_I_HINT |=> !exit_req)
		else $error("hint_instr_a hint raised an exit");
	AST_MISS_MEM: assert property (
		miss_ev |=> mem_go && req_ready)
		else $error("non-exit access not released to memory");
	AST_PRIM_OFF: assert property (
		!prim_on |-> !cls.is_gp ##1 !(exit_req && exit_class == IPQ_CLS_GP))
		else $error("second-level class with primary bit clear");
	// the flop is still in reset on the release edge, so skip that cycle
	AST_PAE_MODE: assert property (
		$past(resetn) |-> pae_active == $past(paging_enable_flag
		&& phys_addr_extension_flag && !long_mode_active_flag))
		else $error("extended paging flag wrong");
	AST_LARGE_SKIP: assert property (
		chk_now && cls.is_gp && cap_third_level_pointer_entry_used
		&& cap_third_level_pointer_entry[LARGE_BIT] && SKIP_LARGE |=> !exit_req)
		else $error("large mapping exit not skipped");
endmodule

// File: common/ipq_pkg.sv
// Purpose: shared constants and types of the access-page exit qualifier
// Assumes: 4-KByte pages; entry bytes carry the low 8 bits of an entry
// Notes: all enums use explicit binary codes
package ipq_pkg;
	localparam int PAGE_SHIFT   = 12;
	localparam int LARGE_BIT    = 7;
	localparam int PRIM_SEC_BIT = 31;
	localparam int ENTRY_W      = 8;
	localparam int ITER_W       = 32;
	localparam logic RST_BIT    = 1'h0;
	localparam logic RST_READY  = 1'h1;
	localparam logic [ITER_W-1:0] RST_ITER = 32'h0;

	typedef enum logic [2:0] {
		IPQ_I_NORMAL = 3'b000,
		IPQ_I_FLUSH  = 3'b001,
		IPQ_I_FRAME  = 3'b010,
		IPQ_I_MASKST = 3'b011,
		IPQ_I_WATCH  = 3'b100,
		IPQ_I_HINT   = 3'b101
	} ipq_instr_t;

	typedef enum logic [1:0] {
		IPQ_A_DATA     = 2'b00,
		IPQ_A_WALK_RD  = 2'b01,
		IPQ_A_PTR_LOAD = 2'b10,
		IPQ_A_AD_UPD   = 2'b11
	} ipq_acc_t;

	typedef enum logic [1:0] {
		IPQ_S_IDLE   = 2'b00,
		IPQ_S_CHECK  = 2'b01,
		IPQ_S_ADWAIT = 2'b10
	} ipq_state_t;

	typedef enum logic {
		IPQ_CLS_LIN = 1'b0,
		IPQ_CLS_GP  = 1'b1
	} ipq_class_t;
endpackage

// File: common/ipq_cls_if.sv
// Purpose: carries one access's attributes to the classifier and back
// Assumes: driven from the qualifier's capture registers and its paging flag and control inputs
// Notes: purely combinational bundle
`timescale 1ns/10ps
interface ipq_cls_if;
	logic               paging_enable_flag;
	logic               phys_addr_extension_flag;
	logic               long_mode_active_flag;
	logic               slt_eff;
	logic               from_slt;
	logic               lin_gen;
	logic               lin_xlat;
	ipq_pkg::ipq_acc_t  kind;
	logic               is_gp;
	logic               is_lin;
	logic               pae_act;

	modport cls (
		input  paging_enable_flag, phys_addr_extension_flag,
		input  long_mode_active_flag, slt_eff, from_slt, lin_gen,
		input  lin_xlat, kind,
		output is_gp, is_lin, pae_act
	);
	modport src (
		output paging_enable_flag, phys_addr_extension_flag,
		output long_mode_active_flag, slt_eff, from_slt, lin_gen,
		output lin_xlat, kind,
		input  is_gp, is_lin, pae_act
	);
endinterface

// File: logic/ipq_classify.sv
// Purpose: sorts an access into linear, guest-physical or neither
// Assumes: lin_xlat means the address is the translation of the linear one
// Notes: accesses that are neither are physical and never exit here
`timescale 1ns/10ps
module ipq_classify (
	ipq_cls_if.cls c
);
	import ipq_pkg::*;

	wire pg      = c.paging_enable_flag;
	wire rule_gp;
	wire kind_gp;

	assign c.pae_act = pg & c.phys_addr_extension_flag
		& !c.long_mode_active_flag;
	assign rule_gp = pg & c.slt_eff & c.from_slt
		& (!c.lin_gen | !c.lin_xlat);
	// only a translated address can be guest-physical
	assign kind_gp = pg & c.slt_eff & c.from_slt
		& ((c.kind == IPQ_A_WALK_RD)
		| (c.kind == IPQ_A_AD_UPD)
		| ((c.kind == IPQ_A_PTR_LOAD) & c.pae_act));
	assign c.is_gp  = rule_gp | kind_gp;
	assign c.is_lin = !c.is_gp & c.lin_gen & c.lin_xlat
		& (c.kind == IPQ_A_DATA);
endmodule

// File: logic/ipq_filter.sv
// Purpose: instruction and translation cases that drop or reshape an exit
// Assumes: entry bytes are only meaningful when the matching used bit is set
// Notes: the skip parameters pick the permitted omission
`timescale 1ns/10ps
module ipq_filter #(
	parameter bit ZMASK_FAULTS = 1'b1,
	parameter bit SKIP_LARGE   = 1'b1,
	parameter bit SKIP_STALE   = 1'b1
) (
	// access
	input  wire ipq_pkg::ipq_instr_t         instr,
	input  wire logic                        zero_mask,
	input  wire logic                        is_gp,
	// translation used
	input  wire logic                        third_level_pointer_entry_used,
	input  wire logic [ipq_pkg::ENTRY_W-1:0] third_level_pointer_entry_entry,
	input  wire logic                        pde_used,
	input  wire logic [ipq_pkg::ENTRY_W-1:0] pde_entry,
	input  wire logic                        stale_xlat,
	// result
	output wire logic                        suppress,
	output wire logic                        force_read
);
	import ipq_pkg::*;

	wire hint_c;
	wire zmask_c;
	wire large_c;
	wire stale_c;

	assign hint_c  = instr == IPQ_I_HINT;
	assign zmask_c = (instr == IPQ_I_MASKST) & zero_mask
		& !ZMASK_FAULTS;
	assign large_c = SKIP_LARGE & is_gp
		& ((third_level_pointer_entry_used & third_level_pointer_entry_entry[LARGE_BIT])
		| (pde_used & pde_entry[LARGE_BIT]));
	assign stale_c = SKIP_STALE & stale_xlat;
	assign suppress = hint_c | zmask_c | large_c | stale_c;
	// flush and watch arming only read their address
	assign force_read = (instr == IPQ_I_FLUSH)
		| (instr == IPQ_I_WATCH);
endmodule

// File: tb/ipq_pipe_model.sv
// Purpose: behavioural translation pipeline answering the qualifier
// Assumes: req_ready drops right after the take edge
// Notes: fault qualifiers toggle outside the deciding cycle
`timescale 1ns/10ps
module ipq_pipe_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       resetn,
	// request watch
	input  wire logic       req_valid,
	input  wire logic       req_ready,
	// scenario knobs
	input  wire logic       pf,
	input  wire logic       viol,
	input  wire logic [3:0] chk_dly,
	input  wire logic [3:0] acc_dly,
	input  wire logic [3:0] dirty_dly,
	// answers
	output logic            chk_valid,
	output logic            chk_page_fault,
	output logic            chk_slt_viol,
	output logic            acc_flags_set,
	output logic            dirty_flag_set
);
	logic       busy;
	logic [4:0] cnt;
	logic       noise;
	wire logic  decide = busy && cnt == 5'(chk_dly);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			busy <= 1'h0;
			cnt <= 5'h0;
			noise <= 1'h0;
		end else begin
			noise <= ~noise;
			if (req_valid && req_ready) begin
				busy <= 1'h1;
				cnt <= 5'h1;
			end else if (busy && req_ready)
				busy <= 1'h0;
			else if (busy && cnt != 5'h1F)
				cnt <= cnt + 5'h1;
		end
	end
	assign chk_valid = decide;
	assign chk_page_fault = decide ? pf : noise;
	assign chk_slt_viol = decide ? viol : ~noise;
	// flags land a set time after the checks resolve
	assign acc_flags_set = busy && cnt >= 5'(chk_dly) + 5'(acc_dly);
	assign dirty_flag_set = busy && cnt >= 5'(chk_dly) + 5'(dirty_dly);
endmodule

// File: tb/test_intr_page_access_exit_qualifier.sv
// Purpose: self-checking bench for the access-page exit qualifier
// Assumes: default parameters; one access in flight
// Notes: latency counts cycles from the take edge to the result pulse
`timescale 1ns/10ps
module test_intr_page_access_exit_qualifier;
	import ipq_pkg::*;
	localparam logic [39:0] PG = 40'h00000FEE00;
	localparam logic [2:0]  EX = 3'b100;
	localparam logic [2:0]  FT = 3'b010;
	localparam logic [2:0]  MG = 3'b001;
	logic mclk = 1'h0, resetn = 1'h0, virt_access_ctl = 1'h1;
	logic slt_enable_ctl = 1'h1, paging_enable_flag = 1'h1;
	logic phys_addr_extension_flag = 1'h1, long_mode_active_flag = 1'h0;
	logic [31:0] prim_exec_ctl = 32'h80000000;
	logic [39:0] access_page_base = PG;
	logic [51:0] req_phys_addr = {PG, 12'h3A0};
	logic req_valid = 1'h0, req_lin_gen = 1'h0, req_lin_xlat = 1'h0;
	logic req_from_slt = 1'h0, req_write = 1'h0, req_zero_mask = 1'h0;
	logic req_rep = 1'h0, third_level_pointer_entry_used = 1'h0, pde_used = 1'h0;
	logic stale_xlat = 1'h0, pf = 1'h0, viol = 1'h0;
	ipq_acc_t req_kind = IPQ_A_DATA;
	ipq_instr_t req_instr = IPQ_I_NORMAL;
	logic [31:0] req_iter = 32'h0;
	logic [7:0] third_level_pointer_entry_entry = 8'h0, pde_entry = 8'h0;
	logic [3:0] chk_dly = 4'h1, acc_dly = 4'h1, dirty_dly = 4'h1;
	logic chk_valid, chk_page_fault, chk_slt_viol, acc_flags_set;
	logic dirty_flag_set, req_ready, exit_req, exit_hold_ip;
	logic fault_fwd, mem_go, pae_active;
	ipq_class_t exit_class;
	logic [31:0] exit_iter;
	logic [2:0] res;
	int lat, miscompares = 0, n_checks = 0, cyc = 0;

	ipq_top u_dut (.mclk, .resetn, .virt_access_ctl, .prim_exec_ctl,
		.slt_enable_ctl, .access_page_base, .paging_enable_flag,
		.phys_addr_extension_flag, .long_mode_active_flag, .req_valid,
		.req_ready, .req_phys_addr, .req_lin_gen, .req_lin_xlat,
		.req_from_slt, .req_kind, .req_instr, .req_write, .req_zero_mask,
		.req_rep, .req_iter, .third_level_pointer_entry_used, .third_level_pointer_entry_entry, .pde_used,
		.pde_entry, .stale_xlat, .chk_valid, .chk_page_fault, .chk_slt_viol,
		.acc_flags_set, .dirty_flag_set, .exit_req, .exit_class, .exit_iter,
		.exit_hold_ip, .fault_fwd, .mem_go, .pae_active);
	ipq_pipe_model u_pipe (.mclk, .resetn, .req_valid, .req_ready, .pf,
		.viol, .chk_dly, .acc_dly, .dirty_dly, .chk_valid, .chk_page_fault,
		.chk_slt_viol, .acc_flags_set, .dirty_flag_set);

	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// f = {lin_gen, lin_xlat, from_slt, write}
	task automatic go(input ipq_acc_t k, input ipq_instr_t ins,
		input logic [3:0] f);
		@(posedge mclk);
		req_kind <= k;
		req_instr <= ins;
		{req_lin_gen, req_lin_xlat, req_from_slt, req_write} <= f;
		req_valid <= 1'h1;
		@(posedge mclk);
		req_valid <= 1'h0;
		lat = 0;
		res = 3'h0;
		while (res == 3'h0 && lat < 40) begin
			@(negedge mclk);
			lat++;
			res = {exit_req, fault_fwd, mem_go};
		end
	endtask

	task automatic ex(input string nm, input logic [2:0] r,
		input ipq_class_t c, input int l);
		chk({nm, " result"}, 32'(r), 32'(res));
		chk({nm, " latency"}, l, lat);
		if (r == EX)
			chk({nm, " class"}, 32'(c), 32'(exit_class));
	endtask

	task automatic t_basic();
		go(IPQ_A_DATA, IPQ_I_NORMAL, 4'b1100);
		ex("linear read", EX, IPQ_CLS_LIN, 3);
		chk("plain pointer", 32'h0, 32'(exit_hold_ip));
		@(posedge mclk) req_phys_addr <= {PG + 40'h1, 12'h000};
		go(IPQ_A_DATA, IPQ_I_NORMAL, 4'b1100);
		ex("off page", MG, IPQ_CLS_LIN, 2);
		@(posedge mclk) req_phys_addr <= {PG, 12'hFFF};
		virt_access_ctl <= 1'h0;
		go(IPQ_A_DATA, IPQ_I_NORMAL, 4'b1100);
		ex("virt off", MG, IPQ_CLS_LIN, 2);
		@(posedge mclk) virt_access_ctl <= 1'h1;
		slt_enable_ctl <= 1'h0;
		go(IPQ_A_DATA, IPQ_I_NORMAL, 4'b1100);
		ex("linear no slt", EX, IPQ_CLS_LIN, 3);
		@(posedge mclk) slt_enable_ctl <= 1'h1;
		$display("test basic done");
	endtask

	task automatic t_fault();
		@(posedge mclk) pf <= 1'h1;
		chk_dly <= 4'h3;
		go(IPQ_A_DATA, IPQ_I_NORMAL, 4'b1101);
		ex("page fault", FT, IPQ_CLS_LIN, 4);
		@(posedge mclk) pf <= 1'h0;
		viol <= 1'h1;
		go(IPQ_A_DATA, IPQ_I_NORMAL, 4'b1110);
		ex("lin violation", FT, IPQ_CLS_LIN, 4);
		go(IPQ_A_WALK_RD, IPQ_I_NORMAL, 4'b0010);
		ex("gp violation", FT, IPQ_CLS_GP, 4);
		@(posedge mclk) viol <= 1'h0;
		chk_dly <= 4'h1;
		$display("test fault done");
	endtask

	task automatic t_flags();
		@(posedge mclk) acc_dly <= 4'h4;
		dirty_dly <= 4'h2;
		go(IPQ_A_DATA, IPQ_I_NORMAL, 4'b1100);
		ex("accessed wait", EX, IPQ_CLS_LIN, 6);
		@(posedge mclk) acc_dly <= 4'h1;
		dirty_dly <= 4'h5;
		go(IPQ_A_DATA, IPQ_I_NORMAL, 4'b1101);
		ex("dirty wait", EX, IPQ_CLS_LIN, 7);
		go(IPQ_A_DATA, IPQ_I_FLUSH, 4'b1101);
		ex("flush as read", EX, IPQ_CLS_LIN, 3);
		go(IPQ_A_DATA, IPQ_I_WATCH, 4'b1101);
		ex("watch as read", EX, IPQ_CLS_LIN, 3);
		@(posedge mclk) dirty_dly <= 4'h1;
		$display("test flags done");
	endtask

	task automatic t_instr();
		go(IPQ_A_DATA, IPQ_I_FRAME, 4'b1100);
		ex("frame probe", EX, IPQ_CLS_LIN, 3);
		@(posedge mclk) req_zero_mask <= 1'h1;
		go(IPQ_A_DATA, IPQ_I_MASKST, 4'b1101);
		ex("zero mask store", EX, IPQ_CLS_LIN, 3);
		@(posedge mclk) req_zero_mask <= 1'h0;
		go(IPQ_A_DATA, IPQ_I_HINT, 4'b1100);
		ex("hint", MG, IPQ_CLS_LIN, 2);
		for (int n = 7; n >= 0; n -= 7) begin
			@(posedge mclk) req_rep <= 1'h1;
			req_iter <= 32'(n);
			go(IPQ_A_DATA, IPQ_I_NORMAL, 4'b1101);
			ex("string exit", EX, IPQ_CLS_LIN, 3);
			chk("string iterations", n, exit_iter);
			chk("string pointer", 32'h1, 32'(exit_hold_ip));
		end
		@(posedge mclk) req_rep <= 1'h0;
		$display("test instr done");
	endtask

	task automatic t_gp();
		go(IPQ_A_WALK_RD, IPQ_I_NORMAL, 4'b0010);
		ex("walk read", EX, IPQ_CLS_GP, 2);
		go(IPQ_A_PTR_LOAD, IPQ_I_NORMAL, 4'b0010);
		ex("pointer load", EX, IPQ_CLS_GP, 2);
		go(IPQ_A_AD_UPD, IPQ_I_NORMAL, 4'b1010);
		ex("flag update", EX, IPQ_CLS_GP, 2);
		go(IPQ_A_DATA, IPQ_I_NORMAL, 4'b1010);
		ex("untranslated linear", EX, IPQ_CLS_GP, 2);
		go(IPQ_A_DATA, IPQ_I_NORMAL, 4'b0010);
		ex("non-linear data", EX, IPQ_CLS_GP, 2);
		go(IPQ_A_WALK_RD, IPQ_I_NORMAL, 4'b0000);
		ex("not translated", MG, IPQ_CLS_GP, 2);
		@(posedge mclk) paging_enable_flag <= 1'h0;
		go(IPQ_A_WALK_RD, IPQ_I_NORMAL, 4'b0010);
		ex("paging off", MG, IPQ_CLS_GP, 2);
		@(posedge mclk) paging_enable_flag <= 1'h1;
		prim_exec_ctl <= 32'h7FFFFFFF;
		go(IPQ_A_WALK_RD, IPQ_I_NORMAL, 4'b0010);
		ex("secondary off", MG, IPQ_CLS_GP, 2);
		@(posedge mclk) prim_exec_ctl <= 32'h80000000;
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk) {paging_enable_flag, phys_addr_extension_flag,
				long_mode_active_flag} <= 3'(i);
			@(posedge mclk);
			@(negedge mclk);
			chk("extended paging", 32'(i == 6), 32'(pae_active));
		end
		@(posedge mclk) {paging_enable_flag, phys_addr_extension_flag,
			long_mode_active_flag} <= 3'b110;
		$display("test gp done");
	endtask

	task automatic t_skip();
		@(posedge mclk) third_level_pointer_entry_used <= 1'h1;
		third_level_pointer_entry_entry <= 8'h80;
		go(IPQ_A_WALK_RD, IPQ_I_NORMAL, 4'b0010);
		ex("1G mapping", MG, IPQ_CLS_GP, 2);
		@(posedge mclk) third_level_pointer_entry_entry <= 8'h7F;
		go(IPQ_A_WALK_RD, IPQ_I_NORMAL, 4'b0010);
		ex("small third level", EX, IPQ_CLS_GP, 2);
		@(posedge mclk) third_level_pointer_entry_used <= 1'h0;
		pde_used <= 1'h1;
		pde_entry <= 8'h80;
		go(IPQ_A_AD_UPD, IPQ_I_NORMAL, 4'b0010);
		ex("2M mapping", MG, IPQ_CLS_GP, 2);
		@(posedge mclk) pde_entry <= 8'h7F;
		go(IPQ_A_AD_UPD, IPQ_I_NORMAL, 4'b0010);
		ex("small directory", EX, IPQ_CLS_GP, 2);
		@(posedge mclk) pde_used <= 1'h0;
		stale_xlat <= 1'h1;
		go(IPQ_A_WALK_RD, IPQ_I_NORMAL, 4'b0010);
		ex("stale gp", MG, IPQ_CLS_GP, 2);
		go(IPQ_A_DATA, IPQ_I_NORMAL, 4'b1110);
		ex("stale linear", MG, IPQ_CLS_LIN, 2);
		@(posedge mclk) stale_xlat <= 1'h0;
		$display("test skip done");
	endtask

	initial begin
		repeat (3) @(posedge mclk);
		resetn <= 1'h1;
		t_basic();
		t_fault();
		t_flags();
		t_instr();
		t_gp();
		t_skip();
		finish_test();
	end
endmodule
